// ---- frame_search_regs.svh ----
`ifndef FRAME_SEARCH_REGS_SVH
`define FRAME_SEARCH_REGS_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define FS_ADDR_W          9
`define FS_STATUS_ADDR     9'h017
`define FS_STATUS_FIXED    8'h20
`define FS_BIT_DIR         0
`define FS_BIT_ACTIVE      1
`define FS_BIT_TIMEOUT     2
`define FS_BIT_FOUND       3
`define FS_BIT_INVALID     4

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define FS_CLK_KHZ         50000
`define FS_TO_T1_MS        12
`define FS_TO_LONG_MS      24
`define FS_TO_E1_MS        8
`define FS_FORCE_MAX_MS    24

`endif

// ---- frame_search_pkg.sv ----
package frame_search_pkg;

  // --------------------------------------------------------------------------
  // framing modes, grouped by their search time-out
  // --------------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    MODE_T1_TERMINAL = 3'h0,
    MODE_T1_SF       = 3'h1,
    MODE_T1_CARRIER  = 3'h2,
    MODE_T1_ESF      = 3'h3,
    MODE_E1          = 3'h4
  } frame_mode_t;

  typedef enum logic [1:0]
  {
    HUNT_FAS  = 2'h0,
    HUNT_MFAS = 2'h1,
    HUNT_CAS  = 2'h2,
    HUNT_NONE = 2'h3
  } e1_stage_t;

  typedef enum logic
  {
    ST_IDLE   = 1'b0,
    ST_SEARCH = 1'b1
  } fs_state_t;

endpackage : frame_search_pkg

// ---- search_timer.sv ----
module search_timer #(
  parameter int TW = 22
) (
  input  wire logic          i_clk,
  input  wire logic          i_resetn,
  input  wire logic          i_start,
  input  wire logic [TW-1:0] i_load,
  output logic               o_expired
);

  logic [TW-1:0] cnt_r;
  logic [TW-1:0] cnt_nxt;
  logic          exp_r;
  logic          exp_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    exp_nxt = 1'b0;
    if (i_start)
    begin
      cnt_nxt = i_load;
    end
    else if (cnt_r != '0)
    begin
      cnt_nxt = cnt_r - TW'(1);
      exp_nxt = (cnt_r == TW'(1));
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_r <= '0;
      exp_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign o_expired = exp_r;

endmodule : search_timer

// ---- alignment_change_counter.sv ----
module alignment_change_counter #(
  parameter int CW = 8
) (
  input  wire logic          i_clk,
  input  wire logic          i_resetn,
  input  wire logic          i_inc,
  output logic [CW-1:0]      o_count
);

  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;

  // wraps to zero after the all-ones count; no overflow flag is kept
  always_comb
  begin
    count_nxt = i_inc ? count_r + CW'(1) : count_r;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      count_r <= '0;
    end
    else
    begin
      count_r <= count_nxt;
    end
  end

  assign o_count = count_r;

endmodule : alignment_change_counter

// ---- offline_frame_search.sv ----
`include "frame_search_regs.svh"
// Operation
// - one search engine shared by receive and transmit directions
// - forced reframe or frame-loss request starts a search
// - search ends on found, abort, time-out or all candidates gone
// - direction flag updated at search entry; 1 receive, 0 transmit
// - no-candidate bit set only when search ends with no candidate
// - found bit set only when exactly one candidate remains
// - on success the searched direction's frame loss is cleared
// - on success engine goes idle; a pending request starts the next search one cycle later
// - on success realign receive, transmit or transmit bus timebase
// - count receive alignment moves; transmit moves not counted
// - time-out bit clears at entry; set if several candidates remain
// - time-out is 12, 24 or 8 ms by framing mode
// - forced search runs once, at most 24 ms before time-out
// - after time-out restart at once if frame loss still asserted
// - forced request self-clears at entry; frame loss status untouched
// - result bits may last one cycle before a new search
// - E1 receive search reports frame, multiframe, signalling hunt
module offline_frame_search
  import frame_search_pkg::*;
#(
  parameter int CNT_W       = 8,
  parameter int POS_W       = 12,
  parameter int TW          = 22,
  parameter int TO_T1_CYC   = `FS_TO_T1_MS * `FS_CLK_KHZ,
  parameter int TO_LONG_CYC = `FS_TO_LONG_MS * `FS_CLK_KHZ,
  parameter int TO_E1_CYC   = `FS_TO_E1_MS * `FS_CLK_KHZ,
  parameter int FORCE_CYC   = `FS_FORCE_MAX_MS * `FS_CLK_KHZ
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_rd,
  input  wire logic [`FS_ADDR_W-1:0] i_addr,
  input  wire logic                 i_rx_force_req,
  input  wire logic                 i_tx_force_req,
  input  wire logic                 i_rx_frame_loss,
  input  wire logic                 i_tx_frame_loss,
  input  wire logic                 i_rx_search_abort,
  input  wire logic                 i_tx_search_abort,
  input  wire frame_mode_t          i_rx_mode,
  input  wire frame_mode_t          i_tx_mode,
  input  wire logic                 i_tx_embedded,
  input  wire logic                 i_cand_eval,
  input  wire logic [7:0]           i_cand_count,
  input  wire logic [POS_W-1:0]     i_rx_cand_pos,
  input  wire logic [POS_W-1:0]     i_rx_cur_pos,
  input  wire e1_stage_t            i_e1_stage,
  output logic [7:0]                o_rdata,
  output logic                      o_rx_forced_reframe,
  output logic                      o_tx_forced_reframe,
  output logic                      o_rx_lof_clear,
  output logic                      o_tx_lof_clear,
  output logic                      o_rx_realign,
  output logic                      o_tx_realign,
  output logic                      o_tsb_realign,
  output logic [CNT_W-1:0]          o_alignment_change_counter,
  output logic                      o_e1_frame_hunt_status,
  output logic                      o_e1_multiframe_hunt_status,
  output logic                      o_e1_signaling_hunt_status
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [TW-1:0] mode_timeout(input frame_mode_t m);
    case (m)
      MODE_T1_TERMINAL, MODE_T1_SF: mode_timeout = TW'(TO_T1_CYC);
      MODE_T1_CARRIER, MODE_T1_ESF: mode_timeout = TW'(TO_LONG_CYC);
      MODE_E1:                      mode_timeout = TW'(TO_E1_CYC);
      default:                      mode_timeout = TW'(TO_LONG_CYC);
    endcase
  endfunction : mode_timeout

  // --------------------------------------------------------------------------
  // search state
  // --------------------------------------------------------------------------
  fs_state_t state_r;
  fs_state_t state_nxt;
  logic      dir_r;
  logic      dir_nxt;
  logic      found_r;
  logic      found_nxt;
  logic      invalid_r;
  logic      invalid_nxt;
  logic      timeout_r;
  logic      timeout_nxt;
  logic      rx_force_r;
  logic      rx_force_nxt;
  logic      tx_force_r;
  logic      tx_force_nxt;
  logic      rx_lofc_nxt;
  logic      tx_lofc_nxt;
  logic      rx_real_nxt;
  logic      tx_real_nxt;
  logic      tsb_real_nxt;
  logic      alignment_change_counter_inc;
  logic      timer_start;
  logic [TW-1:0] timer_load;
  logic      timer_exp;
  logic      rx_req;
  logic      tx_req;
  logic      pick_rx;
  logic      cur_abort;
  logic [TW-1:0] to_sel;

  assign rx_req    = rx_force_r | i_rx_frame_loss;
  assign tx_req    = tx_force_r | i_tx_frame_loss;
  // alternate when both pend so neither direction starves the shared engine
  assign pick_rx   = rx_req & (~tx_req | ~dir_r);
  assign cur_abort = dir_r ? i_rx_search_abort : i_tx_search_abort;

  always_comb
  begin
    state_nxt    = state_r;
    dir_nxt      = dir_r;
    found_nxt    = found_r;
    invalid_nxt  = invalid_r;
    timeout_nxt  = timeout_r;
    rx_force_nxt = rx_force_r;
    tx_force_nxt = tx_force_r;
    rx_lofc_nxt  = 1'b0;
    tx_lofc_nxt  = 1'b0;
    rx_real_nxt  = 1'b0;
    tx_real_nxt  = 1'b0;
    tsb_real_nxt = 1'b0;
    alignment_change_counter_inc     = 1'b0;
    timer_start  = 1'b0;
    timer_load   = '0;
    to_sel       = pick_rx ? mode_timeout(i_rx_mode) : mode_timeout(i_tx_mode);
    case (state_r)
      ST_IDLE:
      begin
        if (rx_req | tx_req)
        begin
          state_nxt   = ST_SEARCH;
          dir_nxt     = pick_rx;
          found_nxt   = 1'b0;
          invalid_nxt = 1'b0;
          timeout_nxt = 1'b0;
          timer_start = 1'b1;
          // a forced search never outlasts the forced ceiling
          timer_load  = ((pick_rx ? rx_force_r : tx_force_r) && to_sel > TW'(FORCE_CYC))
                        ? TW'(FORCE_CYC) : to_sel;
          rx_force_nxt = rx_force_r & ~pick_rx;
          tx_force_nxt = tx_force_r & pick_rx;
        end
      end
      ST_SEARCH:
      begin
        if (cur_abort)
        begin
          state_nxt = ST_IDLE;
        end
        else if ((i_cand_eval || timer_exp) && i_cand_count == 8'h01)
        begin
          state_nxt    = ST_IDLE;
          found_nxt    = 1'b1;
          rx_lofc_nxt  = dir_r;
          tx_lofc_nxt  = ~dir_r;
          rx_real_nxt  = dir_r;
          tx_real_nxt  = ~dir_r & ~i_tx_embedded;
          tsb_real_nxt = ~dir_r & i_tx_embedded;
          alignment_change_counter_inc     = dir_r && (i_rx_cand_pos != i_rx_cur_pos);
        end
        else if (i_cand_eval && i_cand_count == 8'h00)
        begin
          state_nxt   = ST_IDLE;
          invalid_nxt = 1'b1;
        end
        else if (timer_exp)
        begin
          state_nxt = ST_IDLE;
          invalid_nxt = (i_cand_count == 8'h00);
          timeout_nxt = (i_cand_count != 8'h00);
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // a new force request in the clearing cycle survives
    rx_force_nxt = rx_force_nxt | i_rx_force_req;
    tx_force_nxt = tx_force_nxt | i_tx_force_req;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_r        <= ST_IDLE;
      dir_r          <= 1'b0;
      found_r        <= 1'b0;
      invalid_r      <= 1'b0;
      timeout_r      <= 1'b0;
      rx_force_r     <= 1'b0;
      tx_force_r     <= 1'b0;
      o_rx_lof_clear <= 1'b0;
      o_tx_lof_clear <= 1'b0;
      o_rx_realign   <= 1'b0;
      o_tx_realign   <= 1'b0;
      o_tsb_realign  <= 1'b0;
    end
    else
    begin
      state_r        <= state_nxt;
      dir_r          <= dir_nxt;
      found_r        <= found_nxt;
      invalid_r      <= invalid_nxt;
      timeout_r      <= timeout_nxt;
      rx_force_r     <= rx_force_nxt;
      tx_force_r     <= tx_force_nxt;
      o_rx_lof_clear <= rx_lofc_nxt;
      o_tx_lof_clear <= tx_lofc_nxt;
      o_rx_realign   <= rx_real_nxt;
      o_tx_realign   <= tx_real_nxt;
      o_tsb_realign  <= tsb_real_nxt;
    end
  end

  assign o_rx_forced_reframe = rx_force_r;
  assign o_tx_forced_reframe = tx_force_r;

  search_timer #(
    .TW (TW)
  ) u_timer (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_start   (timer_start),
    .i_load    (timer_load),
    .o_expired (timer_exp)
  );

  alignment_change_counter #(
    .CW (CNT_W)
  ) u_alignment_change_counter (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_inc    (alignment_change_counter_inc),
    .o_count  (o_alignment_change_counter)
  );

  // --------------------------------------------------------------------------
  // status read and E1 hunt reporting
  // --------------------------------------------------------------------------
  logic [7:0] status;
  logic [7:0] rdata_nxt;
  logic       fh_nxt;
  logic       mh_nxt;
  logic       sh_nxt;
  logic       e1_rx_hunt;

  always_comb
  begin
    status = `FS_STATUS_FIXED;
    status[`FS_BIT_DIR]     = dir_r;
    status[`FS_BIT_ACTIVE]  = (state_r == ST_SEARCH);
    status[`FS_BIT_TIMEOUT] = timeout_r;
    status[`FS_BIT_FOUND]   = found_r;
    status[`FS_BIT_INVALID] = invalid_r;
    // reads only sample; no flag is touched by the access
    rdata_nxt = (i_rd && i_addr == `FS_STATUS_ADDR) ? status : 8'h00;
    e1_rx_hunt = (state_r == ST_SEARCH) && dir_r && (i_rx_mode == MODE_E1);
    fh_nxt = e1_rx_hunt && (i_e1_stage == HUNT_FAS);
    mh_nxt = e1_rx_hunt && (i_e1_stage == HUNT_MFAS);
    sh_nxt = e1_rx_hunt && (i_e1_stage == HUNT_CAS);
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_rdata                     <= 8'h00;
      o_e1_frame_hunt_status      <= 1'b0;
      o_e1_multiframe_hunt_status <= 1'b0;
      o_e1_signaling_hunt_status  <= 1'b0;
    end
    else
    begin
      o_rdata                     <= rdata_nxt;
      o_e1_frame_hunt_status      <= fh_nxt;
      o_e1_multiframe_hunt_status <= mh_nxt;
      o_e1_signaling_hunt_status  <= sh_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  logic [TW-1:0] search_cyc_r;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      search_cyc_r <= '0;
    end
    else
    begin
      search_cyc_r <= (state_r == ST_SEARCH) ? search_cyc_r + TW'(1) : '0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_entry_dir: assert property ((state_r == ST_IDLE && rx_req && !tx_req) |=>
    (state_r == ST_SEARCH && dir_r)) else $error("receive request did not start search");
  a_entry_clear: assert property ($rose(state_r == ST_SEARCH) |->
    (!timeout_r && !found_r && !invalid_r)) else $error("result bits not cleared at entry");
  a_abort_stop: assert property ((state_r == ST_SEARCH && cur_abort) |=>
    (state_r == ST_IDLE && !found_r && !timeout_r && !invalid_r)) else $error("abort failed");
  a_found_lof: assert property ($rose(found_r) |->
    (o_rx_lof_clear != o_tx_lof_clear && o_rx_lof_clear == dir_r)) else $error("bad lof clear");
  a_found_single: assert property ($rose(found_r) |->
    $past(i_cand_count) == 8'h01) else $error("found without single candidate");
  a_realign_dir: assert property ((o_tx_realign || o_tsb_realign) |->
    (!dir_r && found_r && !o_rx_realign)) else $error("transmit realign mismatch");
  a_tx_nocount: assert property ((o_tx_realign || o_tsb_realign) |->
    $stable(o_alignment_change_counter)) else $error("transmit change counted");
  a_force_selfclr: assert property (($rose(state_r == ST_SEARCH) && dir_r
    && !$past(i_rx_force_req)) |-> !o_rx_forced_reframe) else $error("force not cleared");
  a_timeout_restart: assert property ((state_r == ST_SEARCH && timer_exp && !cur_abort
    && !i_cand_eval && i_rx_frame_loss) ##1 i_rx_frame_loss |=> state_r == ST_SEARCH)
    else $error("no restart after time-out");
  a_search_bound: assert property (search_cyc_r <= TW'(TO_LONG_CYC + 1))
    else $error("search exceeded longest time-out");
  a_status_fixed: assert property ((o_rdata != 8'h00) |-> o_rdata[7:5] == 3'h1)
    else $error("status upper bits wrong");
  a_e1_hunt: assert property (o_e1_frame_hunt_status |->
    $past(state_r == ST_SEARCH && dir_r)) else $error("frame hunt outside receive search");

  c_found: cover property ($rose(found_r));
  c_timeout: cover property ($rose(timeout_r));
  c_invalid: cover property ($rose(invalid_r));
  c_abort: cover property (state_r == ST_SEARCH && cur_abort);

endmodule : offline_frame_search

// ---- framer_loss_model.sv ----
// ----------------------------------------------------------------------------
// online framer stand-in: holds one direction's frame-loss request
// ----------------------------------------------------------------------------
module framer_loss_model (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_declare,
  input  wire logic i_regain,
  input  wire logic i_lof_clear,
  output logic      o_frame_loss
);
  timeunit 1ns;
  timeprecision 1ps;

  logic loss_r;
  logic loss_nxt;

  always_comb
  begin
    loss_nxt = i_declare | (loss_r & ~i_lof_clear & ~i_regain);
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      loss_r <= 1'b0;
    else
      loss_r <= loss_nxt;
  end

  // drop at once on the clear pulse, so a found search is not relaunched
  assign o_frame_loss = loss_r & ~i_lof_clear;
endmodule : framer_loss_model

// ---- tb_offline_frame_search.sv ----
module tb_offline_frame_search;
  timeunit 1ns;
  timeprecision 1ps;
  import frame_search_pkg::*;

  localparam logic [8:0] ST_ADDR = 9'h017;
  logic i_clk, i_resetn, i_rd, i_rx_force_req, i_tx_force_req, i_rx_frame_loss;
  logic i_tx_frame_loss, i_rx_search_abort, i_tx_search_abort, i_tx_embedded, i_cand_eval;
  logic [8:0] i_addr;
  frame_mode_t i_rx_mode, i_tx_mode;
  logic [7:0] i_cand_count, o_rdata, o_alignment_change_counter;
  logic [11:0] i_rx_cand_pos, i_rx_cur_pos;
  e1_stage_t i_e1_stage;
  logic o_rx_forced_reframe, o_tx_forced_reframe, o_rx_lof_clear, o_tx_lof_clear;
  logic o_rx_realign, o_tx_realign, o_tsb_realign, o_e1_frame_hunt_status;
  logic o_e1_multiframe_hunt_status, o_e1_signaling_hunt_status;
  logic rx_declare, tx_declare, rx_regain;
  int   bad_count, num_checks, cyc_count;

  offline_frame_search #(.TO_T1_CYC(40), .TO_LONG_CYC(80), .TO_E1_CYC(30), .FORCE_CYC(60)) dut_u (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_rd(i_rd), .i_addr(i_addr),
    .i_rx_force_req(i_rx_force_req), .i_tx_force_req(i_tx_force_req),
    .i_rx_frame_loss(i_rx_frame_loss), .i_tx_frame_loss(i_tx_frame_loss),
    .i_rx_search_abort(i_rx_search_abort), .i_tx_search_abort(i_tx_search_abort),
    .i_rx_mode(i_rx_mode), .i_tx_mode(i_tx_mode), .i_tx_embedded(i_tx_embedded),
    .i_cand_eval(i_cand_eval), .i_cand_count(i_cand_count),
    .i_rx_cand_pos(i_rx_cand_pos), .i_rx_cur_pos(i_rx_cur_pos), .i_e1_stage(i_e1_stage),
    .o_rdata(o_rdata), .o_rx_forced_reframe(o_rx_forced_reframe),
    .o_tx_forced_reframe(o_tx_forced_reframe), .o_rx_lof_clear(o_rx_lof_clear),
    .o_tx_lof_clear(o_tx_lof_clear), .o_rx_realign(o_rx_realign),
    .o_tx_realign(o_tx_realign), .o_tsb_realign(o_tsb_realign),
    .o_alignment_change_counter(o_alignment_change_counter),
    .o_e1_frame_hunt_status(o_e1_frame_hunt_status),
    .o_e1_multiframe_hunt_status(o_e1_multiframe_hunt_status),
    .o_e1_signaling_hunt_status(o_e1_signaling_hunt_status));

  framer_loss_model rx_framer_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_declare(rx_declare),
    .i_regain(rx_regain), .i_lof_clear(o_rx_lof_clear), .o_frame_loss(i_rx_frame_loss));
  framer_loss_model tx_framer_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_declare(tx_declare),
    .i_regain(1'b0), .i_lof_clear(o_tx_lof_clear), .o_frame_loss(i_tx_frame_loss));

  always #10 i_clk = ~i_clk;

  // --------------------------------------------------------------------------
  // compares, bus cycles, closing
  // --------------------------------------------------------------------------
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_byte

  task automatic check_range(input int got, input int lo, input int hi, input string what);
    num_checks++;
    if (got < lo || got > hi)
    begin
      bad_count++;
      $display("wrong value at %0t: %s got %0d", $time, what, got);
    end
  endtask : check_range

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic read_reg(input logic [8:0] addr, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= addr;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : read_reg

  task automatic cand(input logic [7:0] count);
    @(posedge i_clk);
    i_cand_eval <= 1'b1;
    i_cand_count <= count;
    @(posedge i_clk);
    i_cand_eval <= 1'b0;
    #1;
  endtask : cand

  // success in one direction; cand_pos against fixed current position 001
  task automatic found_case(input logic rx, input logic emb, input logic [11:0] cp,
                            input logic [7:0] exp_cnt);
    logic [7:0] d;
    @(posedge i_clk);
    rx_declare <= rx;
    tx_declare <= !rx;
    i_tx_embedded <= emb;
    i_rx_cand_pos <= cp;
    @(posedge i_clk);
    rx_declare <= 1'b0;
    tx_declare <= 1'b0;
    read_reg(ST_ADDR, d);
    check_byte(d, 8'h22 | {7'h00, rx}, "entry");
    cand(8'h01);
    check_byte({o_rx_lof_clear, o_tx_lof_clear}, {6'h00, rx, !rx}, "lof clear");
    check_byte({o_rx_realign, o_tx_realign, o_tsb_realign},
               {5'h00, rx, !rx && !emb, !rx && emb}, "realign");
    check_byte(o_alignment_change_counter, exp_cnt, "alignment count");
    read_reg(ST_ADDR, d);
    check_byte(d, 8'h28 | {7'h00, rx}, "found");
    $display("test found rx=%0d emb=%0d done", rx, emb);
  endtask : found_case

  task automatic force_invalid(input logic rx);
    logic [7:0] d;
    @(posedge i_clk);
    i_rx_force_req <= rx;
    i_tx_force_req <= !rx;
    @(posedge i_clk);
    i_rx_force_req <= 1'b0;
    i_tx_force_req <= 1'b0;
    #1 check_byte({o_rx_forced_reframe, o_tx_forced_reframe}, {6'h00, rx, !rx}, "force");
    @(posedge i_clk);
    #1 check_byte({o_rx_forced_reframe, o_tx_forced_reframe}, 8'h00, "self clear");
    read_reg(ST_ADDR, d);
    check_byte(d, 8'h22 | {7'h00, rx}, "forced entry");
    cand(8'h00);
    check_byte({o_rx_lof_clear, o_tx_lof_clear}, 8'h00, "no clear");
    read_reg(ST_ADDR, d);
    check_byte(d, 8'h30 | {7'h00, rx}, "invalid");
    $display("test forced invalid rx=%0d done", rx);
  endtask : force_invalid

  task automatic end_search;
    logic [7:0] d;
    @(posedge i_clk);
    i_rd <= 1'b0;
    rx_regain <= 1'b1;
    @(posedge i_clk);
    rx_regain <= 1'b0;
    i_rx_search_abort <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rx_search_abort <= 1'b0;
    read_reg(ST_ADDR, d);
    check_byte(d, 8'h21, "abort");
  endtask : end_search

  always @(posedge i_clk)
  begin
    cyc_count++;
    if (cyc_count == 20000)
    begin
      bad_count++;
      $display("wrong value at %0t: run did not finish", $time);
      stop_test();
    end
  end

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial
  begin : main_seq
    logic [7:0]  d, d1;
    int          n;
    frame_mode_t modes[5] = '{MODE_T1_TERMINAL, MODE_T1_SF, MODE_T1_CARRIER, MODE_T1_ESF, MODE_E1};
    int          lens[5] = '{40, 40, 80, 80, 30};
    {i_clk, i_resetn, i_rd, i_rx_force_req, i_tx_force_req, i_rx_search_abort} = '0;
    {i_tx_search_abort, i_tx_embedded, i_cand_eval, rx_declare, tx_declare, rx_regain} = '0;
    {bad_count, num_checks, cyc_count} = '0;
    i_addr = ST_ADDR;
    i_rx_mode = MODE_T1_SF;
    i_tx_mode = MODE_T1_ESF;
    i_cand_count = 8'h00;
    i_rx_cand_pos = 12'h001;
    i_rx_cur_pos = 12'h001;
    i_e1_stage = HUNT_NONE;
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    read_reg(ST_ADDR, d);
    check_byte(d, 8'h20, "reset status");
    read_reg(9'h016, d);
    check_byte(d, 8'h00, "unmapped");
    found_case(1'b1, 1'b0, 12'h005, 8'h01);
    found_case(1'b1, 1'b0, 12'h001, 8'h01);
    found_case(1'b0, 1'b0, 12'h009, 8'h01);
    found_case(1'b0, 1'b1, 12'h009, 8'h01);
    force_invalid(1'b1);
    force_invalid(1'b0);
    // both forced at once: one search, then the other one at once
    @(posedge i_clk);
    i_rx_force_req <= 1'b1;
    i_tx_force_req <= 1'b1;
    @(posedge i_clk);
    i_rx_force_req <= 1'b0;
    i_tx_force_req <= 1'b0;
    read_reg(ST_ADDR, d1);
    check_byte(d1, 8'h23, "first direction");
    cand(8'h01);
    read_reg(ST_ADDR, d);
    check_byte({d[1], d[0]}, {6'h00, 1'b1, ~d1[0]}, "second direction");
    cand(8'h01);
    $display("test shared engine done");
    // forced transmit search: capped below the mode time-out, run once only
    @(posedge i_clk);
    i_tx_force_req <= 1'b1;
    i_cand_count <= 8'h02;
    @(posedge i_clk);
    i_tx_force_req <= 1'b0;
    i_rd <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clk);
      #1 n++;
    end while (o_rdata[2] !== 1'b1 && n < 200);
    check_range(n, 60, 64, "forced length");
    @(posedge i_clk);
    #1 check_byte(o_rdata, 8'h24, "forced single");
    // transmit abort right after entry
    @(posedge i_clk);
    i_rd <= 1'b0;
    i_tx_force_req <= 1'b1;
    @(posedge i_clk);
    i_tx_force_req <= 1'b0;
    i_tx_search_abort <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_tx_search_abort <= 1'b0;
    read_reg(ST_ADDR, d);
    check_byte(d, 8'h20, "transmit abort");
    $display("test forced transmit time-out and abort done");
    for (int k = 0; k < 5; k++)
    begin
      @(posedge i_clk);
      i_rx_mode <= modes[k];
      i_cand_count <= 8'h02;
      rx_declare <= 1'b1;
      @(posedge i_clk);
      rx_declare <= 1'b0;
      i_rd <= 1'b1;
      n = 0;
      do
      begin
        @(posedge i_clk);
        #1 n++;
      end while (o_rdata[2] !== 1'b1 && n < 200);
      check_range(n, lens[k], lens[k] + 4, "search length");
      @(posedge i_clk);
      #1 check_byte(o_rdata & 8'h07, 8'h03, "restart");
      end_search();
      $display("test time-out mode %0d done", k);
    end
    // receive hunt stages in E1 mode, one cycle behind the stage input
    @(posedge i_clk);
    rx_declare <= 1'b1;
    @(posedge i_clk);
    rx_declare <= 1'b0;
    repeat (2) @(posedge i_clk);
    for (int s = 0; s < 3; s++)
    begin
      i_e1_stage <= e1_stage_t'(s);
      @(posedge i_clk);
      #1 check_byte({5'h00, o_e1_signaling_hunt_status, o_e1_multiframe_hunt_status,
                     o_e1_frame_hunt_status}, 8'h01 << s, "hunt stage");
      @(posedge i_clk);
    end
    i_e1_stage <= HUNT_NONE;
    end_search();
    $display("test e1 hunt done");
    stop_test();
  end : main_seq
endmodule : tb_offline_frame_search
